// [core/acc_pkg.sv]
// constants and state type for the auxiliary channel calibration block
// assumes one core clock and a plain strobe register port
package acc_pkg;
    // register byte addresses
    localparam logic [15:0] ACC_GAIN1_ADDR = 16'h2240;
    localparam logic [15:0] ACC_OFF1_ADDR = 16'h2244;
    localparam logic [15:0] ACC_OFF1P5_ADDR = 16'h22CC;
    // value field occupies bits 14..0, bits above read zero
    localparam int ACC_FIELD_MSB = 14;
    localparam int ACC_FIELD_W = 15;
    // reset values of the value fields
    localparam logic [14:0] ACC_GAIN_RST = 15'h4000;
    localparam logic [14:0] ACC_OFF_RST = 15'h0000;
    // fixed-point facts: gain has 14 fraction bits, offset 2
    localparam logic [14:0] ACC_GAIN_ZERO = 15'h0000;
    localparam logic [14:0] ACC_GAIN_UNITY = 15'h4000;
    localparam logic [15:0] ACC_ILLEGAL_OUT = 16'h8000;
    localparam int ACC_SHIFT = 16;
    localparam logic signed [35:0] ACC_ROUND = 36'sh000008000;
    localparam logic signed [35:0] ACC_FULL = 36'sh00000FFFF;
    // channel kinds seen at the raw result input
    localparam logic [1:0] ACC_CH_VOLT = 2'h0;
    localparam logic [1:0] ACC_CH_TIA = 2'h1;
    localparam logic [1:0] ACC_CH_TEMP = 2'h2;
    // amplifier gain codes
    localparam logic [1:0] ACC_PGA_1 = 2'h0;
    localparam logic [1:0] ACC_PGA_1P5 = 2'h1;
    // whole state of the block
    typedef struct packed {
        logic [14:0] gain1;
        logic [14:0] off1;
        logic [14:0] off1p5;
        logic [31:0] rdata;
        logic out_valid;
        logic [15:0] out_data;
    } acc_state_t;
endpackage

// [core/acc_calib.sv]
// offset and gain correction of auxiliary channel conversion results
// assumes raw results and channel codes arrive synchronous to core_clk
`timescale 1ns/1ns
module acc_calib (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic raw_valid,
    input wire logic [15:0] conversion_result_word,
    input wire logic [1:0] chan_kind,
    input wire logic [1:0] pga_gain,
    output logic corr_valid,
    output logic [15:0] corr_result
);
    // registered state and its next copy
    acc_pkg::acc_state_t cur;
    acc_pkg::acc_state_t next_cur;

    // path selection for the current raw sample
    logic volt_ch; // not a tia or temperature channel
    logic use_g1; // gain-1 offset and factor apply
    logic use_g1p5; // gain-1.5 offset applies
    logic [14:0] sel_off; // chosen offset code
    logic [14:0] sel_gain; // chosen gain code
    // arithmetic intermediates
    logic signed [19:0] raw_q; // raw result in quarter LSBs
    logic signed [19:0] off_q; // offset sign extended
    logic signed [19:0] sum_q; // raw plus offset
    logic signed [35:0] prod; // sum times gain
    logic signed [35:0] scaled; // back to whole LSBs
    logic [15:0] corr_val; // saturated corrected value

    // read decode of the register map; unmapped words read zero
    function automatic logic [31:0] acc_read(
        input logic [15:0] addr,
        input acc_pkg::acc_state_t s
    );
        logic [31:0] v;
        v = 32'h00000000;
        case (addr)
            acc_pkg::ACC_GAIN1_ADDR: begin
                v[acc_pkg::ACC_FIELD_MSB:0] = s.gain1;
            end
            acc_pkg::ACC_OFF1_ADDR: begin
                v[acc_pkg::ACC_FIELD_MSB:0] = s.off1;
            end
            acc_pkg::ACC_OFF1P5_ADDR: begin
                v[acc_pkg::ACC_FIELD_MSB:0] = s.off1p5;
            end
            default: begin
                v = 32'h00000000;
            end
        endcase
        return v;
    endfunction

    // choose the calibration set from channel kind and amplifier gain
    always_comb begin
        volt_ch = (chan_kind != acc_pkg::ACC_CH_TIA) &&
            (chan_kind != acc_pkg::ACC_CH_TEMP);
        // tia and temperature channels never see these factors
        use_g1 = volt_ch && (pga_gain == acc_pkg::ACC_PGA_1);
        use_g1p5 = volt_ch && (pga_gain == acc_pkg::ACC_PGA_1P5);
        if (use_g1) begin
            sel_off = cur.off1;
            sel_gain = cur.gain1;
        end else if (use_g1p5) begin
            // its own gain register lives elsewhere, so unity here
            sel_off = cur.off1p5;
            sel_gain = acc_pkg::ACC_GAIN_UNITY;
        end else begin
            // other paths pass through untouched
            sel_off = acc_pkg::ACC_OFF_RST;
            sel_gain = acc_pkg::ACC_GAIN_UNITY;
        end
    end

    // correction datapath: offset first, then gain, then clamp
    always_comb begin
        // two fraction bits make the raw word line up with the offset
        raw_q = $signed({2'b00, conversion_result_word, 2'b00});
        // sign-extend so 0x4000 reads as -4096 and 0x7FFF as -0.25
        off_q = $signed({{5{sel_off[14]}}, sel_off});
        sum_q = raw_q + off_q;
        // gain is a positive factor with 14 fraction bits, so the
        // top code still means just under two rather than a negative number
        prod = sum_q * $signed({1'b0, sel_gain});
        // drop 2 + 14 fraction bits with round to nearest
        scaled = (prod + acc_pkg::ACC_ROUND) >>> acc_pkg::ACC_SHIFT;
        // saturate instead of wrapping: a wrapped code would look
        // like a valid reading at the far end of the scale
        if (scaled < 0) begin
            corr_val = 16'h0000;
        end else if (scaled > acc_pkg::ACC_FULL) begin
            corr_val = 16'hFFFF;
        end else begin
            corr_val = scaled[15:0];
        end
        // illegal zero gain gives the fixed mid-scale code
        if (use_g1 && (cur.gain1 == acc_pkg::ACC_GAIN_ZERO)) begin
            corr_val = acc_pkg::ACC_ILLEGAL_OUT;
        end
    end

    // next-state logic: register writes, read data, result stage
    always_comb begin
        next_cur = cur;
        // read data only stands in the cycle after the strobe
        next_cur.rdata = 32'h00000000;
        if (reg_wr) begin
            case (reg_addr)
                acc_pkg::ACC_GAIN1_ADDR: begin
                    next_cur.gain1 = reg_wdata[14:0];
                end
                acc_pkg::ACC_OFF1_ADDR: begin
                    next_cur.off1 = reg_wdata[14:0];
                end
                acc_pkg::ACC_OFF1P5_ADDR: begin
                    next_cur.off1p5 = reg_wdata[14:0];
                end
                default: begin
                    // writes to unmapped words are dropped
                    next_cur.gain1 = cur.gain1;
                end
            endcase
        end
        if (reg_rd) begin
            next_cur.rdata = acc_read(reg_addr, cur);
        end
        // one result per raw sample, one cycle later
        next_cur.out_valid = raw_valid;
        if (raw_valid) begin
            next_cur.out_data = corr_val;
        end
    end

    // reset image of the state, constants only, so the reset branch
    // never depends on anything that is itself being reset
    localparam acc_pkg::acc_state_t RST_STATE = '{
        gain1: acc_pkg::ACC_GAIN_RST,
        off1: acc_pkg::ACC_OFF_RST,
        off1p5: acc_pkg::ACC_OFF_RST,
        rdata: 32'h00000000,
        out_valid: 1'b0,
        out_data: 16'h0000
    };

    // state register with synchronous active-low reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cur <= RST_STATE;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = cur.rdata;
    assign corr_valid = cur.out_valid;
    assign corr_result = cur.out_data;

    // checks tying each output code to its calibration cause

    // zero gain on the gain-1 path must yield mid-scale
    a_gain_zero_out: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h0000)
        |=> (corr_valid && corr_result == 16'h8000))
        else $error("zero gain did not give mid-scale code");

    // unity gain and zero offset reproduce the raw word
    a_unity_pass: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h4000 &&
        cur.off1 == 15'h0000)
        |=> (corr_result == $past(conversion_result_word)))
        else $error("unity gain changed the result");

    // half gain rounds the raw word to half
    a_half_gain: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h2000 &&
        cur.off1 == 15'h0000)
        |=> (corr_result ==
        16'((17'($past(conversion_result_word)) + 17'h00001) >> 1)))
        else $error("half gain result wrong");

    // four quarter steps of offset add one whole count
    a_quarter_step: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h4000 &&
        cur.off1 == 15'h0004 && conversion_result_word != 16'hFFFF)
        |=> (corr_result == $past(conversion_result_word) + 16'h0001))
        else $error("offset step size wrong");

    // most negative offset takes 4096 counts, clamped at zero
    a_neg_offset: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h4000 &&
        cur.off1 == 15'h4000)
        |=> (corr_result == (($past(conversion_result_word) >= 16'h1000)
        ? $past(conversion_result_word) - 16'h1000 : 16'h0000)))
        else $error("negative offset wrong");

    // tia and temperature channels bypass the correction
    a_tia_bypass: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && !volt_ch)
        |=> (corr_result == $past(conversion_result_word)))
        else $error("non-voltage channel was corrected");

    // gain-1.5 path uses its own offset register
    a_p5_offset: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1p5 && cur.off1p5 == 15'h0004 &&
        conversion_result_word != 16'hFFFF)
        |=> (corr_result == $past(conversion_result_word) + 16'h0001))
        else $error("gain 1.5 offset not applied");

    // doubling full scale must clamp, not wrap
    a_gain_sat: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h7FFF &&
        cur.off1 == 15'h0000 && conversion_result_word == 16'hFFFF)
        |=> (corr_result == 16'hFFFF))
        else $error("result did not saturate");

    // top gain code very nearly doubles a mid value
    a_gain_double: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h7FFF &&
        cur.off1 == 15'h0000 && conversion_result_word == 16'h1000)
        |=> (corr_result == 16'h2000))
        else $error("top gain code not near two");

    // gain-1 offset is used on the aux gain-1 path
    a_g1_offset: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h4000 &&
        cur.off1 == 15'h0008 && conversion_result_word < 16'hFFFE)
        |=> (corr_result == $past(conversion_result_word) + 16'h0002))
        else $error("gain 1 offset not applied");

    // fractional gain code just above unity leaves small values
    a_gain_frac: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && use_g1 && cur.gain1 == 15'h4001 &&
        cur.off1 == 15'h0000 && conversion_result_word == 16'h0100)
        |=> (corr_result == 16'h0100))
        else $error("fine gain step too coarse");

    // checks on the timing and read path of both interfaces

    // one strobe per sample, exactly one cycle after it
    a_valid_pulse: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        $past(rst_b) |-> (corr_valid == $past(raw_valid)))
        else $error("result strobe out of step with samples");

    // the corrected word holds between samples
    a_result_hold: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        ($past(rst_b) && !$past(raw_valid)) |-> $stable(corr_result))
        else $error("result changed without a sample");

    // read data stands only in the cycle after a read strobe
    a_rdata_idle: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        ($past(rst_b) && !$past(reg_rd)) |-> (reg_rdata == 32'h00000000))
        else $error("read data present without a read");

    // bits above the 15-bit field always read zero
    a_rdata_upper: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        reg_rdata[31:15] == 17'h00000)
        else $error("reserved read bits not zero");

    // a gain read returns the factor held when the strobe came
    a_gain_read: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        ($past(rst_b) && $past(reg_rd) &&
        ($past(reg_addr) == acc_pkg::ACC_GAIN1_ADDR))
        |-> (reg_rdata == {17'h00000, $past(cur.gain1)}))
        else $error("gain read data wrong");

    // other amplifier gains take no correction at all
    a_other_pga: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (raw_valid && volt_ch && !use_g1 && !use_g1p5)
        |=> (corr_result == $past(conversion_result_word)))
        else $error("other amplifier gain was corrected");
endmodule

// [tb/tb.sv]
// self-checking bench for the auxiliary channel calibration block
// assumes core/acc_pkg.sv and core/acc_calib.sv are compiled first
`timescale 1ns/1ns
module tb;
    logic core_clk = 1'b0; // 250 MHz core clock
    logic rst_b = 1'b0; // synchronous reset, active low
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic raw_valid = 1'b0;
    logic [15:0] raw = 16'h0000;
    logic [1:0] chan_kind = 2'h0;
    logic [1:0] pga_gain = 2'h0;
    logic corr_valid;
    logic [15:0] corr_result;
    int mismatches = 0; // failed comparisons
    int checked = 0; // comparisons made
    logic [14:0] offs [4] = '{15'h3FFF, 15'h0001, 15'h7FFF, 15'h4000};
    logic [14:0] gains [6] = '{15'h4000, 15'h2000, 15'h7FFF, 15'h4001,
        15'h3FFF, 15'h0001};

    // free-running clock
    always #2 core_clk = ~core_clk;

    acc_calib DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .raw_valid(raw_valid),
        .conversion_result_word(raw), .chan_kind(chan_kind),
        .pga_gain(pga_gain), .corr_valid(corr_valid),
        .corr_result(corr_result));

    // reference arithmetic: quarter-lsb offset, 14 fraction bit gain, clamp
    function automatic logic [15:0] model(logic [15:0] r, logic [14:0] o,
        logic [14:0] g);
        logic signed [35:0] v;
        logic signed [35:0] p;
        v = $signed({18'h0, r, 2'b00}) + $signed({{21{o[14]}}, o});
        p = (v * $signed({21'h0, g}) + 36'sh8000) >>> 16;
        if (p < 0) return 16'h0000;
        if (p > 36'sh0FFFF) return 16'hFFFF;
        return p[15:0];
    endfunction

    task automatic finish_test();
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp_reg(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected register %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_res(logic v, logic [15:0] got, logic [15:0] exp);
        checked++;
        if (v !== 1'b1 || got !== exp) begin
            mismatches++;
            $display("unexpected result %0t got %h/%h want 1/%h", $time, v,
                got, exp);
        end
    endtask

    // one write strobe cycle
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read strobe, data judged in the following cycle only
    task automatic rd(logic [15:0] a, logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp_reg(reg_rdata, exp);
    endtask

    // one sample; the corrected word is registered one cycle later
    task automatic smp(logic [15:0] r, logic [1:0] k, logic [1:0] p,
        logic [15:0] exp);
        @(posedge core_clk);
        raw_valid <= 1'b1;
        raw <= r;
        chan_kind <= k;
        pga_gain <= p;
        @(posedge core_clk);
        raw_valid <= 1'b0;
        #1 cmp_res(corr_valid, corr_result, exp);
    endtask

    // reset values, reserved bits, unmapped place
    task automatic t_regs();
        rd(acc_pkg::ACC_GAIN1_ADDR, 32'h00004000);
        rd(acc_pkg::ACC_OFF1_ADDR, 32'h0);
        rd(acc_pkg::ACC_OFF1P5_ADDR, 32'h0);
        wr(acc_pkg::ACC_OFF1P5_ADDR, 32'hFFFF_C001);
        rd(acc_pkg::ACC_OFF1P5_ADDR, 32'h00004001);
        wr(16'h2248, 32'h1234);
        rd(16'h2248, 32'h0);
    endtask

    // every documented offset code, including the negative clamp
    task automatic t_offset();
        foreach (offs[i]) begin
            wr(acc_pkg::ACC_OFF1_ADDR, {17'h0, offs[i]});
            smp(16'h1000, 2'h0, 2'h0, model(16'h1000, offs[i], 15'h4000));
            smp(16'h0000, 2'h0, 2'h0, model(16'h0000, offs[i], 15'h4000));
        end
        wr(acc_pkg::ACC_OFF1_ADDR, 32'h0);
    endtask

    // every documented gain code, with the top clamp reached
    task automatic t_gain();
        foreach (gains[i]) begin
            wr(acc_pkg::ACC_GAIN1_ADDR, {17'h0, gains[i]});
            smp(16'h7FFF, 2'h0, 2'h0, model(16'h7FFF, 15'h0, gains[i]));
            smp(16'hC000, 2'h3, 2'h0, model(16'hC000, 15'h0, gains[i]));
        end
        wr(acc_pkg::ACC_GAIN1_ADDR, 32'h2000);
        smp(16'h4002, 2'h0, 2'h0, 16'h2001);
    endtask

    // illegal zero gain, then channel and amplifier routing
    task automatic t_route();
        wr(acc_pkg::ACC_GAIN1_ADDR, 32'h0);
        smp(16'h1234, 2'h0, 2'h0, 16'h8000);
        wr(acc_pkg::ACC_GAIN1_ADDR, 32'h6000);
        wr(acc_pkg::ACC_OFF1_ADDR, 32'h0010);
        wr(acc_pkg::ACC_OFF1P5_ADDR, 32'h7FF0);
        smp(16'h1000, 2'h1, 2'h0, 16'h1000);
        smp(16'h1000, 2'h2, 2'h0, 16'h1000);
        smp(16'h1000, 2'h0, 2'h0, model(16'h1000, 15'h0010, 15'h6000));
        smp(16'h1000, 2'h0, 2'h1, model(16'h1000, 15'h7FF0, 15'h4000));
        smp(16'h1000, 2'h0, 2'h2, 16'h1000);
    endtask

    // corner codes: fine and top gain steps, single offset steps
    task automatic t_corner();
        wr(acc_pkg::ACC_OFF1_ADDR, 32'h0);
        wr(acc_pkg::ACC_GAIN1_ADDR, 32'h4001);
        rd(acc_pkg::ACC_GAIN1_ADDR, 32'h00004001);
        smp(16'h0100, 2'h0, 2'h0, 16'h0100);
        smp(16'h8000, 2'h0, 2'h0, 16'h8002);
        wr(acc_pkg::ACC_GAIN1_ADDR, 32'h7FFF);
        smp(16'h1000, 2'h0, 2'h0, 16'h2000);
        smp(16'hFFFF, 2'h0, 2'h0, 16'hFFFF);
        wr(acc_pkg::ACC_GAIN1_ADDR, 32'h4000);
        wr(acc_pkg::ACC_OFF1_ADDR, 32'h0004);
        smp(16'h0ABC, 2'h0, 2'h0, 16'h0ABD);
        wr(acc_pkg::ACC_OFF1_ADDR, 32'h0008);
        smp(16'h0ABC, 2'h0, 2'h0, 16'h0ABE);
        wr(acc_pkg::ACC_OFF1P5_ADDR, 32'h0004);
        smp(16'h0ABC, 2'h0, 2'h1, 16'h0ABD);
    endtask

    // watchdog against a hang
    initial begin
        #40000;
        mismatches++;
        finish_test();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs();
        t_offset();
        t_gain();
        t_route();
        t_corner();
        finish_test();
    end
endmodule
